/* design/lptm_entry_timer.sv */
/*
 * Power-state entry delay timer.  Accumulates elapsed time units while the
 * entry condition holds and flags entry once the programmed delay is met.
 * Assumes a synchronous active-low reset and a core-clock condition input.
 */
`timescale 1ns/1ps

module lptm_entry_timer #(
    parameter int W = 16,
    parameter int TICK_CYCLES = 1,
    parameter int STEP = 1
) (
    input wire logic core_clk,
    input wire logic rst_b,
    lptm_timer_if.tmr tif
);
    import lptm_pkg::*;

    localparam int ACC_W = W + 8;
    localparam int PRE_W = $clog2(TICK_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(STEP);

    logic [PRE_W-1:0] pre_r;
    logic [ACC_W-1:0] acc_r;
    logic enter_r;
    logic tick;
    logic reached;

    assign tick = (pre_r == PRE_LAST);
    assign reached = (acc_r >= {{(ACC_W-W){1'b0}}, tif.limit});

    // Unit prescaler, realigned whenever the condition drops
    always_ff @(posedge core_clk) begin
        if (!rst_b || !tif.cond || tick) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + PRE_W'(1);
        end
    end

    // Elapsed units; any break in the condition restarts the count
    always_ff @(posedge core_clk) begin
        if (!rst_b || !tif.cond) begin
            acc_r <= '0;
        end else if (!reached && tick) begin
            acc_r <= acc_r + ACC_STEP;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            enter_r <= 1'b0;
        end else begin
            enter_r <= tif.cond && reached;
        end
    end

    assign tif.enter = enter_r;

endmodule : lptm_entry_timer

/* design/lptm_ifs.sv */
/*
 * Interfaces between the register slice and its two helpers:
 * an entry timer channel and the interrupt message composer.
 * Assumes all parties run on the same core clock.
 */
`timescale 1ns/1ps

interface lptm_timer_if #(parameter int W = 16);
    logic [W-1:0] limit;
    logic cond;
    logic enter;

    modport ctl (output limit, output cond, input enter);
    modport tmr (input limit, input cond, output enter);
endinterface : lptm_timer_if

interface lptm_msi_if;
    logic enable;
    logic req;
    logic [31:0] upper;
    logic [31:0] lower;
    logic [15:0] data;
    logic valid;
    logic wide;
    logic [63:0] addr;
    logic [31:0] wdata;

    modport ctl (output enable, output req, output upper, output lower,
                 output data, input valid, input wide, input addr,
                 input wdata);
    modport gen (input enable, input req, input upper, input lower,
                 input data, output valid, output wide, output addr,
                 output wdata);
endinterface : lptm_msi_if

/* design/lptm_msi_gen.sv */
/*
 * Interrupt message composer.  On a request while messages are enabled it
 * presents one memory write: address, width choice and data, for a cycle.
 * Assumes request is a one-cycle pulse on the core clock.
 */
`timescale 1ns/1ps

module lptm_msi_gen (
    input wire logic core_clk,
    input wire logic rst_b,
    lptm_msi_if.gen mif
);
    import lptm_pkg::*;

    logic valid_r;
    logic wide_r;
    logic [63:0] addr_r;
    logic [31:0] wdata_r;
    logic upper_used;

    assign upper_used = (mif.upper != 32'h0000_0000);

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            valid_r <= 1'b0;
        end else begin
            valid_r <= mif.req && mif.enable;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wide_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
        end else if (mif.req && mif.enable) begin
            wide_r <= upper_used;
            addr_r <= upper_used ? {mif.upper, mif.lower}
                                 : {32'h0000_0000, mif.lower};
            wdata_r <= {16'h0000, mif.data};
        end
    end

    assign mif.valid = valid_r;
    assign mif.wide = wide_r;
    assign mif.addr = addr_r;
    assign mif.wdata = wdata_r;

endmodule : lptm_msi_gen

/* design/lptm_pkg.sv */
/*
 * Constants for the link power timer and interrupt message register slice:
 * register offsets, field positions, reset values and timing figures.
 * Assumes a single core clock of 100 ns period.
 */
package lptm_pkg;

    // -------------------------------------------------------------------
    // Register offsets (byte addresses)
    // -------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_POWER_TIMERS = 8'h78;
    localparam logic [7:0] OFF_MSI_CAP_CTL = 8'h7c;
    localparam logic [7:0] OFF_MSI_LOWER = 8'h80;
    localparam logic [7:0] OFF_MSI_UPPER = 8'h84;
    localparam logic [7:0] OFF_MSI_DATA = 8'h88;

    // -------------------------------------------------------------------
    // Field layout
    // -------------------------------------------------------------------
    localparam int L1_DELAY_LSB = 0;
    localparam int L1_DELAY_W = 16;
    localparam int L0S_DELAY_LSB = 16;
    localparam int L0S_DELAY_W = 12;
    localparam int LAYOUT_SEL_BIT = 31;
    localparam int CAP_ID_LSB = 0;
    localparam int NEXT_PTR_LSB = 8;
    localparam int MSI_EN_BIT = 16;
    localparam int MSG_CAPABLE_LSB = 17;
    localparam int MSG_ENABLED_LSB = 20;
    localparam int WIDE_ADDR_BIT = 23;
    localparam int LOWER_ADDR_LSB = 2;
    localparam int MSG_DATA_W = 16;

    // -------------------------------------------------------------------
    // Reset and fixed values
    // -------------------------------------------------------------------
    localparam logic [15:0] L1_DELAY_RST = 16'h03e8;
    localparam logic [11:0] L0S_DELAY_RST = 12'h6d6;
    localparam logic LAYOUT_SEL_RST = 1'b0;
    localparam logic [7:0] CAP_ID_MSI = 8'h05;
    localparam logic [7:0] NEXT_PTR_LAST = 8'h00;
    localparam logic [2:0] MSG_COUNT_ONE = 3'h0;
    localparam logic WIDE_ADDR_YES = 1'b1;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int L1_UNIT_NS = 1000;
    localparam int L0S_UNIT_NS = 4;
    // Core cycles per L1 unit, rounded down, at least one
    localparam int L1_TICK_CYCLES = (L1_UNIT_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                    (L1_UNIT_NS / CLK_PERIOD_NS);
    // L0s units that elapse in one core cycle
    localparam int L0S_UNITS_PER_CYCLE =
        (CLK_PERIOD_NS / L0S_UNIT_NS) < 1 ? 1 : (CLK_PERIOD_NS / L0S_UNIT_NS);

endpackage : lptm_pkg

/* design/lptm_regs.sv */
/*
 * Per-port register slice: link power-state entry timers with a layout
 * selector, and the interrupt message capability with its address and
 * data registers.  Drives two entry timers and the message composer.
 * Assumes a plain register port: one-cycle write and read strobes, never
 * together, read data one cycle after the read strobe.
 */
// Summary of operation
// - L1 delay is 16-bit RW, reset 0x3E8; enter L1 after conditions hold.
// - L1 delay counts one-microsecond units; reset gives one millisecond.
// - L1 delay applies on upstream ports only; downstream ignores it.
// - L0s delay is 12-bit RW, reset 0x6D6; enter L0s after conditions hold.
// - L0s delay counts 4 ns units; reset value gives seven microseconds.
// - Top bit selects register layout, RW, resets to zero.
// - Capability identifier byte reads fixed 0x5.
// - Next capability pointer reads zero: last in list.
// - Message enable bit is RW, reset zero, gates message writes.
// - Capable and enabled message counts read zero: one message.
// - Wide address capable bit reads one.
// - Lower message address RW, reset zero; two low bits read zero.
// - Non-zero upper address selects 64-bit message address, else 32-bit.
// - Message data value forms the low data of each message write.
`timescale 1ns/1ps

module lptm_regs #(
    parameter int L1_W = lptm_pkg::L1_DELAY_W,
    parameter int L0S_W = lptm_pkg::L0S_DELAY_W
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [lptm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic upstream_port,
    input wire logic l1_conditions_met,
    input wire logic l0s_conditions_met,
    output logic enter_l1,
    output logic enter_l0s,
    input wire logic msi_request,
    output logic msi_write_valid,
    output logic msi_write_wide,
    output logic [63:0] msi_write_addr,
    output logic [31:0] msi_write_data,
    output logic msi_enabled,
    output logic layout_selector
);
    import lptm_pkg::*;

    // -------------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------------
    logic [L1_W-1:0] l1_entry_delay_r;
    logic [L0S_W-1:0] l0s_entry_delay_r;
    logic layout_selector_r;
    logic msi_enable_r;
    logic [31:LOWER_ADDR_LSB] msi_lower_address_r;
    logic [31:0] msi_upper_address_r;
    logic [MSG_DATA_W-1:0] msi_message_data_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    logic wr_timers;
    logic wr_cap_ctl;
    logic wr_lower;
    logic wr_upper;
    logic wr_data;

    // -------------------------------------------------------------------
    // Write decode
    // -------------------------------------------------------------------
    assign wr_timers = reg_wr && (reg_addr == OFF_POWER_TIMERS);
    assign wr_cap_ctl = reg_wr && (reg_addr == OFF_MSI_CAP_CTL);
    assign wr_lower = reg_wr && (reg_addr == OFF_MSI_LOWER);
    assign wr_upper = reg_wr && (reg_addr == OFF_MSI_UPPER);
    assign wr_data = reg_wr && (reg_addr == OFF_MSI_DATA);

    // -------------------------------------------------------------------
    // Power-state entry timer register
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            l1_entry_delay_r <= L1_W'(L1_DELAY_RST);
        end else if (wr_timers) begin
            l1_entry_delay_r <= reg_wdata[L1_DELAY_LSB +: L1_W];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            l0s_entry_delay_r <= L0S_W'(L0S_DELAY_RST);
        end else if (wr_timers) begin
            l0s_entry_delay_r <= reg_wdata[L0S_DELAY_LSB +: L0S_W];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            layout_selector_r <= LAYOUT_SEL_RST;
        end else if (wr_timers) begin
            layout_selector_r <= reg_wdata[LAYOUT_SEL_BIT];
        end
    end

    // -------------------------------------------------------------------
    // Message capability and control
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            msi_enable_r <= 1'b0;
        end else if (wr_cap_ctl) begin
            msi_enable_r <= reg_wdata[MSI_EN_BIT];
        end
    end

    // -------------------------------------------------------------------
    // Message address and data
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            msi_lower_address_r <= '0;
        end else if (wr_lower) begin
            msi_lower_address_r <= reg_wdata[31:LOWER_ADDR_LSB];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            msi_upper_address_r <= '0;
        end else if (wr_upper) begin
            msi_upper_address_r <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            msi_message_data_r <= '0;
        end else if (wr_data) begin
            msi_message_data_r <= reg_wdata[MSG_DATA_W-1:0];
        end
    end

    // -------------------------------------------------------------------
    // Read path
    // -------------------------------------------------------------------
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (reg_addr)
            OFF_POWER_TIMERS: begin
                // Unused bits stay zero
                rdata_nxt[L1_DELAY_LSB +: L1_W] = l1_entry_delay_r;
                rdata_nxt[L0S_DELAY_LSB +: L0S_W] = l0s_entry_delay_r;
                rdata_nxt[LAYOUT_SEL_BIT] = layout_selector_r;
            end
            OFF_MSI_CAP_CTL: begin
                rdata_nxt[CAP_ID_LSB +: 8] = CAP_ID_MSI;
                rdata_nxt[NEXT_PTR_LSB +: 8] = NEXT_PTR_LAST;
                rdata_nxt[MSI_EN_BIT] = msi_enable_r;
                rdata_nxt[MSG_CAPABLE_LSB +: 3] = MSG_COUNT_ONE;
                rdata_nxt[MSG_ENABLED_LSB +: 3] = MSG_COUNT_ONE;
                rdata_nxt[WIDE_ADDR_BIT] = WIDE_ADDR_YES;
            end
            OFF_MSI_LOWER: begin
                rdata_nxt = {msi_lower_address_r, 2'b00};
            end
            OFF_MSI_UPPER: begin
                rdata_nxt = msi_upper_address_r;
            end
            OFF_MSI_DATA: begin
                rdata_nxt[MSG_DATA_W-1:0] = msi_message_data_r;
            end
            default: begin
                rdata_nxt = 32'h0000_0000;
            end
        endcase
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge core_clk) begin
        if (!rst_b || !reg_rd) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // -------------------------------------------------------------------
    // Entry timers
    // -------------------------------------------------------------------
    lptm_timer_if #(.W(L1_W)) l1_tif ();
    lptm_timer_if #(.W(L0S_W)) l0s_tif ();

    assign l1_tif.limit = l1_entry_delay_r;
    // Downstream ports never arm the L1 timer
    assign l1_tif.cond = l1_conditions_met && upstream_port;
    assign l0s_tif.limit = l0s_entry_delay_r;
    assign l0s_tif.cond = l0s_conditions_met;

    lptm_entry_timer #(
        .W(L1_W),
        .TICK_CYCLES(L1_TICK_CYCLES),
        .STEP(1)
    ) u_l1_timer (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .tif(l1_tif)
    );

    lptm_entry_timer #(
        .W(L0S_W),
        .TICK_CYCLES(1),
        .STEP(L0S_UNITS_PER_CYCLE)
    ) u_l0s_timer (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .tif(l0s_tif)
    );

    assign enter_l1 = l1_tif.enter;
    assign enter_l0s = l0s_tif.enter;

    // -------------------------------------------------------------------
    // Message composer
    // -------------------------------------------------------------------
    lptm_msi_if msi_mif ();

    assign msi_mif.enable = msi_enable_r;
    assign msi_mif.req = msi_request;
    assign msi_mif.upper = msi_upper_address_r;
    assign msi_mif.lower = {msi_lower_address_r, 2'b00};
    assign msi_mif.data = msi_message_data_r;

    lptm_msi_gen u_msi_gen (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .mif(msi_mif)
    );

    assign msi_write_valid = msi_mif.valid;
    assign msi_write_wide = msi_mif.wide;
    assign msi_write_addr = msi_mif.addr;
    assign msi_write_data = msi_mif.wdata;

    // -------------------------------------------------------------------
    // Status outputs
    // -------------------------------------------------------------------
    assign msi_enabled = msi_enable_r;
    assign layout_selector = layout_selector_r;

endmodule : lptm_regs

/* verification/lptm_link_partner.sv */
/*
 * Link partner and message source model: entry conditions and requests.
 * Assumes callers invoke its tasks just after a rising core clock edge.
 */
`timescale 1ns/1ps

module lptm_link_partner (
    input wire logic core_clk,
    output logic l1_ok,
    output logic l0s_ok,
    output logic msi_req
);
    // ---------------------------------------------------------------
    // Drivers
    // ---------------------------------------------------------------
    initial begin
        l1_ok = 1'b0;
        l0s_ok = 1'b0;
        msi_req = 1'b0;
    end

    // Conditions may break at any cycle
    task automatic set_cond(input logic l1, input logic l0s);
        l1_ok <= l1;
        l0s_ok <= l0s;
    endtask : set_cond

    // Back-to-back one-cycle requests
    task automatic pulse_msi(input int cnt);
        repeat (cnt) begin
            msi_req <= 1'b1;
            @(posedge core_clk);
        end
        msi_req <= 1'b0;
    endtask : pulse_msi
endmodule : lptm_link_partner

/* verification/lptm_regs_props.sv */
/*
 * Port checker for the register slice, bound to every lptm_regs.
 * Assumes one core clock and synchronous active-low reset.
 */
`timescale 1ns/1ps

module lptm_regs_props
    import lptm_pkg::*;
#(
    parameter int L1_W = 16,
    parameter int L0S_W = 12
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [lptm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic upstream_port,
    input wire logic l1_conditions_met,
    input wire logic l0s_conditions_met,
    input wire logic enter_l1,
    input wire logic enter_l0s,
    input wire logic msi_request,
    input wire logic msi_write_valid,
    input wire logic msi_write_wide,
    input wire logic [63:0] msi_write_addr,
    input wire logic [31:0] msi_write_data,
    input wire logic msi_enabled,
    input wire logic layout_selector
);
    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    cap_read_a: assert property (
        reg_rd && reg_addr == OFF_MSI_CAP_CTL |=>
        reg_rdata == {8'h00, 1'b1, 6'h00, $past(msi_enabled), 16'h0005})
        else $error("capability word wrong");
    sel_write_a: assert property (
        reg_wr && reg_addr == OFF_POWER_TIMERS |=>
        layout_selector == $past(reg_wdata[31]))
        else $error("layout selector not written");
    en_write_a: assert property (
        reg_wr && reg_addr == OFF_MSI_CAP_CTL |=>
        msi_enabled == $past(reg_wdata[16]))
        else $error("message enable not written");
    l1_down_a: assert property ($rose(enter_l1) |->
        $past(upstream_port) && $past(l1_conditions_met))
        else $error("L1 entry on downstream port");
    l1_drop_a: assert property (!l1_conditions_met |=> !enter_l1)
        else $error("L1 entry without condition");
    l0s_drop_a: assert property (!l0s_conditions_met |=> !enter_l0s)
        else $error("L0s entry without condition");
    msi_go_a: assert property (
        msi_request && msi_enabled |=> msi_write_valid)
        else $error("message write missing");
    msi_gate_a: assert property (!(msi_request && msi_enabled) |=>
        !msi_write_valid)
        else $error("message write not requested");
    msi_shape_a: assert property (
        msi_write_valid |-> msi_write_addr[1:0] == 2'h0
        && msi_write_data[31:16] == 16'h0
        && msi_write_wide == (msi_write_addr[63:32] != 32'h0))
        else $error("message write shape wrong");
endmodule : lptm_regs_props

bind lptm_regs lptm_regs_props #(.L1_W(L1_W), .L0S_W(L0S_W)) u_props (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .upstream_port(upstream_port),
    .l1_conditions_met(l1_conditions_met),
    .l0s_conditions_met(l0s_conditions_met), .enter_l1(enter_l1),
    .enter_l0s(enter_l0s), .msi_request(msi_request),
    .msi_write_valid(msi_write_valid), .msi_write_wide(msi_write_wide),
    .msi_write_addr(msi_write_addr), .msi_write_data(msi_write_data),
    .msi_enabled(msi_enabled), .layout_selector(layout_selector));

/* verification/tb.sv */
/*
 * Self-checking bench for the register slice.
 * Assumes a 100 ns core clock and the plain register port.
 */
`timescale 1ns/1ps

module tb;
    import lptm_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic upstream_port = 1'b1;
    logic [31:0] reg_rdata, msi_message_data, lo, up, md;
    logic l1c, l0sc, mreq, ent_l1, ent_l0s, mv, mw, men, lsel;
    logic [63:0] maddr;
    logic rd_d = 1'b0;
    logic [31:0] seed = 32'he3b23aeb;
    logic [31:0] rd_q[$];
    string nm_q[$];
    logic [96:0] msi_q[$];
    int n_mismatch = 0;
    int checked = 0;
    int n;

    always #50 core_clk = ~core_clk;

    lptm_regs dut (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .upstream_port(upstream_port),
        .l1_conditions_met(l1c), .l0s_conditions_met(l0sc),
        .enter_l1(ent_l1), .enter_l0s(ent_l0s), .msi_request(mreq),
        .msi_write_valid(mv), .msi_write_wide(mw), .msi_write_addr(maddr),
        .msi_write_data(msi_message_data), .msi_enabled(men), .layout_selector(lsel));
    lptm_link_partner u_lp (.core_clk(core_clk), .l1_ok(l1c),
        .l0s_ok(l0sc), .msi_req(mreq));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic check(input string nm, input logic [96:0] seen,
                         input logic [96:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input string nm);
        rd_q.push_back(e);
        nm_q.push_back(nm);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask : rd

    // Cycles from raising a condition to seeing entry
    task automatic measure(input logic l1, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge core_clk);
            #1;
            cnt++;
        end while (cnt < lim && (l1 ? ent_l1 : ent_l0s) !== 1'b1);
        @(posedge core_clk);
    endtask : measure

    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    // ---------------------------------------------------------------
    // Result monitor
    // ---------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rd_d) begin
            check(nm_q.pop_front(), 97'(reg_rdata),
                  97'(rd_q.pop_front()));
        end
        if (mv === 1'b1) begin
            check("msi_write", {mw, maddr, msi_message_data},
                  msi_q.pop_front());
        end
        rd_d <= reg_rd;
    end

    initial begin
        repeat (15000) @(posedge core_clk);
        n_mismatch++;
        close_out();
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        rd(OFF_POWER_TIMERS, 32'h06d6_03e8, "timers_rst");
        rd(OFF_MSI_CAP_CTL, 32'h0080_0005, "cap_rst");
        rd(OFF_MSI_LOWER, 32'h0, "lower_rst");
        rd(OFF_MSI_UPPER, 32'h0, "upper_rst");
        rd(OFF_MSI_DATA, 32'h0, "data_rst");
        u_lp.set_cond(1'b0, 1'b1);
        measure(1'b0, 200, n);
        check("l0s_rst_delay", 97'(n), 97'(71));
        u_lp.set_cond(1'b1, 1'b0);
        measure(1'b1, 12000, n);
        check("l1_rst_delay", 97'(n), 97'(10001));
        u_lp.set_cond(1'b0, 1'b0);
        lo = xs();
        wr(OFF_POWER_TIMERS, lo);
        rd(OFF_POWER_TIMERS, lo & 32'h8fff_ffff, "timers_rw");
        check("layout_sel", 97'(lsel), 97'(lo[31]));
        lo = xs();
        wr(OFF_MSI_LOWER, lo);
        rd(OFF_MSI_LOWER, lo & 32'hffff_fffc, "lower_rw");
        md = xs();
        wr(OFF_MSI_DATA, md);
        rd(OFF_MSI_DATA, md & 32'h0000_ffff, "data_rw");
        wr(8'h90, xs());
        rd(8'h90, 32'h0, "unmapped");
        wr(OFF_MSI_UPPER, 32'h0);
        u_lp.pulse_msi(1);
        wr(OFF_MSI_CAP_CTL, 32'hffff_ffff);
        rd(OFF_MSI_CAP_CTL, 32'h0081_0005, "cap_en");
        check("msi_enabled", 97'(men), 97'(1));
        msi_q.push_back({1'b0, 32'h0, lo & 32'hffff_fffc, 16'h0,
                         md[15:0]});
        u_lp.pulse_msi(1);
        up = xs() | 32'h1;
        wr(OFF_MSI_UPPER, up);
        repeat (2) msi_q.push_back({1'b1, up, lo & 32'hffff_fffc, 16'h0,
                                    md[15:0]});
        u_lp.pulse_msi(2);
        repeat (3) @(posedge core_clk);
        wr(OFF_POWER_TIMERS, 32'h0032_0003);
        u_lp.set_cond(1'b0, 1'b1);
        @(posedge core_clk);
        u_lp.set_cond(1'b0, 1'b0);
        @(posedge core_clk);
        u_lp.set_cond(1'b0, 1'b1);
        measure(1'b0, 50, n);
        check("l0s_restart", 97'(n), 97'(3));
        u_lp.set_cond(1'b1, 1'b0);
        measure(1'b1, 100, n);
        check("l1_delay", 97'(n), 97'(31));
        u_lp.set_cond(1'b0, 1'b0);
        repeat (2) @(posedge core_clk);
        upstream_port <= 1'b0;
        u_lp.set_cond(1'b1, 1'b0);
        measure(1'b1, 60, n);
        check("l1_downstream", 97'(n), 97'(60));
        close_out();
    end
endmodule : tb
